// *** rtl/idp_identify_words.sv ***
`default_nettype none
module idp_identify_words (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [4:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [4:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output idp_pkg::idp_word_t       word_out,
   output logic                     word_valid,
   input  wire logic                word_ready,
   output logic                     busy
);
   typedef struct packed {
      idp_pkg::idp_state_t st;
      logic [7:0]          idx;
      idp_pkg::idp_word_t  word;
      idp_pkg::idp_cfg_t   cfg;
      idp_pkg::idp_cfg_t   snap;
      logic                aw_got;
      logic                w_got;
      logic [4:0]          awaddr;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
   } idp_regs_t;

   idp_regs_t s_q;
   idp_regs_t s_d;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] word_at(input logic [7:0] i,
                                           input idp_pkg::idp_cfg_t c);
      logic [31:0] cap;
      logic [15:0] w;
      cap = 32'(c.cyl) * 32'(c.heads) * 32'(c.spt);
      w = 16'h0000;
      case (i)
         idp_pkg::W_CAP: begin
            w = idp_pkg::V_CAP;
         end
         idp_pkg::W_PIO: begin
            w = idp_pkg::V_PIO;
         end
         idp_pkg::W_VALID: begin
            w = idp_pkg::V_VALID;
         end
         idp_pkg::W_CYL: begin
            w = c.cyl;
         end
         idp_pkg::W_HEAD: begin
            w = {8'h00, c.heads};
         end
         idp_pkg::W_SPT: begin
            w = {8'h00, c.spt};
         end
         idp_pkg::W_CAPL: begin
            w = cap[15:0];
         end
         idp_pkg::W_CAPH: begin
            w = cap[31:16];
         end
         idp_pkg::W_MULT: begin
            w = {idp_pkg::V_MULTH, c.mult};
         end
         idp_pkg::W_LBAL: begin
            w = c.lba[15:0];
         end
         idp_pkg::W_LBAH: begin
            w = c.lba[31:16];
         end
         idp_pkg::W_MDMA: begin
            w = {5'h00, c.mdma_sel, 5'h00,
                 idp_pkg::V_MDSUP};
         end
         idp_pkg::W_APIO: begin
            w = idp_pkg::V_APIO;
         end
         idp_pkg::W_MDMIN: begin
            w = idp_pkg::V_CYCLE;
         end
         idp_pkg::W_MDREC: begin
            w = idp_pkg::V_CYCLE;
         end
         idp_pkg::W_PIONF: begin
            w = idp_pkg::V_CYCLE;
         end
         idp_pkg::W_PIOFC: begin
            w = idp_pkg::V_CYCLE;
         end
         idp_pkg::W_MAJ: begin
            w = idp_pkg::V_MAJ;
         end
         idp_pkg::W_MIN: begin
            w = idp_pkg::V_MIN;
         end
         idp_pkg::W_SUP1: begin
            w = idp_pkg::V_SUP1;
         end
         idp_pkg::W_SUP2: begin
            w = idp_pkg::V_SUP2;
         end
         idp_pkg::W_SUP3: begin
            w = idp_pkg::V_SUP3;
         end
         idp_pkg::W_EN1: begin
            w[14] = c.feat_en[idp_pkg::EN_NOP];
            w[13] = c.feat_en[idp_pkg::EN_RBUF];
            w[12] = c.feat_en[idp_pkg::EN_WBUF];
            w[6]  = c.feat_en[idp_pkg::EN_LOOK];
            w[5]  = c.feat_en[idp_pkg::EN_WCACHE];
            w[3]  = c.feat_en[idp_pkg::EN_PM];
            w[1]  = c.feat_en[idp_pkg::EN_PWD];
         end
         idp_pkg::W_EN2: begin
            w = idp_pkg::V_EN2;
         end
         idp_pkg::W_EN3: begin
            w = idp_pkg::V_EN3;
         end
         idp_pkg::W_UDMA: begin
            w = {3'h0, c.udma_sel, 3'h0,
                 idp_pkg::V_UDSUP};
         end
         idp_pkg::W_ERASE: begin
            w = {8'h00, c.erase};
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction

   // applies a transfer mode code; a bad code leaves the modes untouched
   function automatic idp_pkg::idp_cfg_t set_mode(
         input idp_pkg::idp_cfg_t c, input logic [7:0] code);
      idp_pkg::idp_cfg_t r;
      logic [2:0] m;
      r = c;
      m = code[2:0];
      r.xfer = code;
      r.xerr = 1'b0;
      case (code[7:3])
         idp_pkg::XC_PIODEF: r.xerr = (m > 3'h1);
         idp_pkg::XC_PIOFC:  r.xerr = (m > idp_pkg::MAX_PIO);
         idp_pkg::XC_MDMA: begin
            if (m > idp_pkg::MAX_MDMA) begin
               r.xerr = 1'b1;
            end else begin
               r.mdma_sel = 3'(1 << m);
               r.udma_sel = 5'h00;
            end
         end
         idp_pkg::XC_UDMA: begin
            if (m > idp_pkg::MAX_UDMA) begin
               r.xerr = 1'b1;
            end else begin
               r.udma_sel = 5'(1 << m);
               r.mdma_sel = 3'h0;
            end
         end
         default: r.xerr = 1'b1;
      endcase
      if (r.xerr) begin
         r.mdma_sel = c.mdma_sel;
         r.udma_sel = c.udma_sel;
      end
      return r;
   endfunction

   logic        do_wr;
   logic        do_rd;
   logic        start;
   logic [31:0] regv;
   logic        hit;

   assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
   assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rdata   = s_q.rdata;
   assign word_out      = s_q.word;
   assign word_valid    = (s_q.st == idp_pkg::ST_SEND);
   assign busy          = (s_q.st == idp_pkg::ST_SEND);
   assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign do_rd = s_axi_arvalid && !s_q.rvalid;

   always_comb begin
      s_d   = s_q;
      start = 1'b0;
      regv  = 32'h0000_0000;
      hit   = 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         case ({s_q.awaddr[4:2], 2'b00})
            idp_pkg::OFS_CTRL:
               start = s_q.wstrb[0] && s_q.wdata[idp_pkg::CTRL_START];
            idp_pkg::OFS_GEOM: begin
               regv = merge({s_q.cfg.spt, s_q.cfg.heads, s_q.cfg.cyl},
                            s_q.wdata, s_q.wstrb);
               s_d.cfg.cyl   = regv[15:0];
               s_d.cfg.heads = regv[23:16];
               s_d.cfg.spt   = regv[31:24];
            end
            idp_pkg::OFS_LBA:
               s_d.cfg.lba = merge(s_q.cfg.lba, s_q.wdata, s_q.wstrb);
            idp_pkg::OFS_MULT: begin
               if (s_q.wstrb[0]) begin
                  s_d.cfg.mult = s_q.wdata[7:0];
               end
            end
            idp_pkg::OFS_XFER: begin
               if (s_q.wstrb[0]) begin
                  s_d.cfg = set_mode(s_q.cfg, s_q.wdata[7:0]);
               end
            end
            idp_pkg::OFS_FEAT: begin
               if (s_q.wstrb[0]) begin
                  s_d.cfg.feat_en = s_q.wdata[6:0]
                                  & idp_pkg::FEAT_SUPP_MASK;
               end
               if (s_q.wstrb[1]) begin
                  s_d.cfg.erase = s_q.wdata[15:8];
               end
            end
            idp_pkg::OFS_STAT: hit = 1'b1;
            default: hit = 1'b0;
         endcase
         s_d.bresp = hit ? idp_pkg::RESP_OKAY : idp_pkg::RESP_SLVERR;
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (do_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = idp_pkg::RESP_OKAY;
         case ({s_axi_araddr[4:2], 2'b00})
            idp_pkg::OFS_CTRL: s_d.rdata = 32'h0000_0000;
            idp_pkg::OFS_GEOM:
               s_d.rdata = {s_q.cfg.spt, s_q.cfg.heads, s_q.cfg.cyl};
            idp_pkg::OFS_LBA:  s_d.rdata = s_q.cfg.lba;
            idp_pkg::OFS_MULT: s_d.rdata = {24'h0, s_q.cfg.mult};
            idp_pkg::OFS_XFER:
               s_d.rdata = {23'h0, s_q.cfg.xerr, s_q.cfg.xfer};
            idp_pkg::OFS_FEAT:
               s_d.rdata = {16'h0, s_q.cfg.erase, 1'b0, s_q.cfg.feat_en};
            idp_pkg::OFS_STAT:
               s_d.rdata = {16'h0, s_q.idx, 7'h0, busy};
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = idp_pkg::RESP_SLVERR;
            end
         endcase
      end
      // word stream; a start while sending is ignored so a sector is
      // never torn between two configurations
      case (s_q.st)
         idp_pkg::ST_IDLE: begin
            if (start) begin
               s_d.st        = idp_pkg::ST_SEND;
               s_d.snap      = s_q.cfg;
               s_d.idx       = 8'h00;
               s_d.word.data = word_at(8'h00, s_q.cfg);
               s_d.word.last = 1'b0;
            end
         end
         idp_pkg::ST_SEND: begin
            if (word_ready) begin
               if (s_q.word.last) begin
                  s_d.st        = idp_pkg::ST_IDLE;
                  s_d.word.last = 1'b0;
               end else begin
                  s_d.idx       = s_q.idx + 8'h01;
                  s_d.word.data = word_at(s_q.idx + 8'h01, s_q.snap);
                  s_d.word.last = (s_q.idx + 8'h01 == idp_pkg::W_LAST);
               end
            end
         end
         default: s_d.st = idp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q                <= '0;
         s_q.st             <= idp_pkg::ST_IDLE;
         s_q.cfg.cyl        <= idp_pkg::RST_CYL;
         s_q.cfg.heads      <= idp_pkg::RST_HEADS;
         s_q.cfg.spt        <= idp_pkg::RST_SPT;
         s_q.cfg.mult       <= idp_pkg::RST_MULT;
         s_q.cfg.feat_en    <= idp_pkg::RST_FEAT;
         s_q.cfg.erase      <= idp_pkg::RST_ERASE;
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// *** rtl/idp_pkg.sv ***
`default_nettype none
package idp_pkg;
   localparam int unsigned AW = 5;
   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL   = 5'h00;
   localparam logic [AW-1:0] OFS_GEOM   = 5'h04;
   localparam logic [AW-1:0] OFS_LBA    = 5'h08;
   localparam logic [AW-1:0] OFS_MULT   = 5'h0C;
   localparam logic [AW-1:0] OFS_XFER   = 5'h10;
   localparam logic [AW-1:0] OFS_FEAT   = 5'h14;
   localparam logic [AW-1:0] OFS_STAT   = 5'h18;
   // field positions
   localparam int unsigned CTRL_START   = 0;
   localparam int unsigned STAT_BUSY    = 0;
   localparam int unsigned XFER_ERR     = 8;
   localparam int unsigned FEAT_ERASE   = 8;
   // feature enable bits in the enable register, same order as word 85
   localparam int unsigned EN_NOP = 6, EN_RBUF = 5, EN_WBUF = 4;
   localparam int unsigned EN_LOOK = 3, EN_WCACHE = 2, EN_PM = 1;
   localparam int unsigned EN_PWD = 0;
   localparam logic [6:0] FEAT_SUPP_MASK = 7'h7F;
   // word numbers
   localparam logic [7:0] W_CAP = 8'h31, W_PIO = 8'h33, W_VALID = 8'h35;
   localparam logic [7:0] W_CYL = 8'h36, W_HEAD = 8'h37, W_SPT = 8'h38;
   localparam logic [7:0] W_CAPL = 8'h39, W_CAPH = 8'h3A, W_MULT = 8'h3B;
   localparam logic [7:0] W_LBAL = 8'h3C, W_LBAH = 8'h3D, W_MDMA = 8'h3F;
   localparam logic [7:0] W_APIO = 8'h40, W_MDMIN = 8'h41;
   localparam logic [7:0] W_MDREC = 8'h42, W_PIONF = 8'h43;
   localparam logic [7:0] W_PIOFC = 8'h44, W_MAJ = 8'h50, W_MIN = 8'h51;
   localparam logic [7:0] W_SUP1 = 8'h52, W_SUP2 = 8'h53, W_SUP3 = 8'h54;
   localparam logic [7:0] W_EN1 = 8'h55, W_EN2 = 8'h56, W_EN3 = 8'h57;
   localparam logic [7:0] W_UDMA = 8'h58, W_ERASE = 8'h59;
   localparam logic [7:0] W_LAST = 8'hFF;
   // fixed word contents
   localparam logic [15:0] V_CAP   = 16'h0B00;
   localparam logic [15:0] V_PIO   = 16'h0200;
   localparam logic [15:0] V_VALID = 16'h0007;
   localparam logic [7:0]  V_MULTH = 8'h01;
   localparam logic [2:0]  V_MDSUP = 3'h7;
   localparam logic [15:0] V_APIO  = 16'h0003;
   localparam int unsigned CYCLE_NS = 120;
   localparam logic [15:0] V_CYCLE = 16'(CYCLE_NS);
   localparam logic [15:0] V_MAJ   = 16'h007E;
   localparam logic [15:0] V_MIN   = 16'h0019;
   localparam logic [15:0] V_SUP1  = 16'h706B;
   localparam logic [15:0] V_SUP2  = 16'h400C;
   localparam logic [15:0] V_SUP3  = 16'h4000;
   localparam logic [15:0] V_EN2   = 16'h0100;
   localparam logic [15:0] V_EN3   = 16'h4000;
   localparam logic [4:0]  V_UDSUP = 5'h1F;
   // transfer mode code classes, upper five bits
   localparam logic [4:0] XC_PIODEF = 5'h00, XC_PIOFC = 5'h01;
   localparam logic [4:0] XC_MDMA = 5'h04, XC_UDMA = 5'h08;
   localparam logic [2:0] MAX_PIO = 3'h4, MAX_MDMA = 3'h2, MAX_UDMA = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
   // reset values
   localparam logic [15:0] RST_CYL = 16'h0000;
   localparam logic [7:0]  RST_HEADS = 8'h00, RST_SPT = 8'h00;
   localparam logic [7:0]  RST_MULT = 8'h00, RST_ERASE = 8'h00;
   localparam logic [6:0]  RST_FEAT = 7'h00;

   typedef struct packed {
      logic [15:0] data;
      logic        last;
   } idp_word_t;

   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0]  heads;
      logic [7:0]  spt;
      logic [31:0] lba;
      logic [7:0]  mult;
      logic [2:0]  mdma_sel;
      logic [4:0]  udma_sel;
      logic [6:0]  feat_en;
      logic [7:0]  erase;
      logic [7:0]  xfer;
      logic        xerr;
   } idp_cfg_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } idp_state_t;
endpackage
`default_nettype wire

// *** tb/idp_checker.sv ***
`default_nettype none
module idp_checker (
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire idp_pkg::idp_word_t word_out,
   input wire logic               word_valid,
   input wire logic               word_ready,
   input wire logic               busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] idx_q;
   logic [7:0] idx_d;
   // index of the word on offer; idle forces zero so each sector starts clean
   always_comb begin
      idx_d = idx_q;
      if (!word_valid) idx_d = 8'h00;
      else if (word_ready) idx_d = idx_q + 8'h01;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) idx_q <= 8'h00;
      else idx_q <= idx_d;
   end
   a_word_hold: assert property (word_valid && !word_ready |=>
      word_valid && $stable(word_out)) else $error("word changed in stall");
   a_busy_mirror: assert property (busy == word_valid)
      else $error("busy differs from valid");
   a_last_flag: assert property (word_valid |->
      word_out.last == (idx_q == 8'hFF)) else $error("last misplaced");
   a_last_end: assert property (word_valid && word_ready && word_out.last
      |=> !word_valid) else $error("stream ran past 256 words");
   a_cap_bits: assert property (word_valid && idx_q == 8'h31 |->
      word_out.data == 16'h0B00) else $error("capabilities word wrong");
   a_valid_bits: assert property (word_valid && idx_q == 8'h35 |->
      word_out.data == 16'h0007) else $error("validity word wrong");
   a_mult_high: assert property (word_valid && idx_q == 8'h3B |->
      word_out.data[15:8] == 8'h01) else $error("multiple flag wrong");
   a_mdma_one: assert property (word_valid && idx_q == 8'h3F |->
      $onehot0(word_out.data[10:8]) && word_out.data[2:0] == 3'h7)
      else $error("dma mode word wrong");
   a_minor_ver: assert property (word_valid && idx_q == 8'h51 |->
      word_out.data == 16'h0019) else $error("minor version wrong");
   a_reserved_zero: assert property (word_valid && idx_q > 8'h59 |->
      word_out.data == 16'h0000) else $error("reserved word not zero");
endmodule
`default_nettype wire

// *** tb/idp_host_model.sv ***
`default_nettype none
module idp_host_model (
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire idp_pkg::idp_word_t word_out,
   input wire logic               word_valid,
   output logic                   word_ready,
   input wire logic               slow,
   output int                     n_got
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   logic [1:0]  tick;
   // slow mode takes one word in four, like a host pacing its cycles
   always @(posedge aclk) begin
      if (!aresetn) begin
         word_ready <= 1'b0;
         tick <= 2'h0;
         n_got <= 0;
      end else begin
         tick <= tick + 2'h1;
         word_ready <= !slow || tick == 2'h3;
         if (word_valid && word_ready) begin
            mem[n_got % 256] <= word_out.data;
            n_got <= n_got + 1;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic               aclk, aresetn, slow, word_ready, word_valid, busy;
   logic [4:0]         s_axi_awaddr, s_axi_araddr;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic               s_axi_rready;
   logic [31:0]        s_axi_wdata, s_axi_rdata, rdat, lba;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
   logic [15:0]        cyl;
   logic [7:0]         heads, spt, mult, erase;
   logic [6:0]         feat;
   logic [2:0]         mdma;
   logic [4:0]         udma;
   idp_pkg::idp_word_t word_out;
   int                 n_got, n_mismatch, checks;
   // transfer codes in order: good and bad of every class
   localparam logic [103:0] CODES = {8'h00, 8'h01, 8'h02, 8'h0C, 8'h0D,
      8'h10, 8'h40, 8'h44, 8'h45, 8'h20, 8'h21, 8'h23, 8'h22};

   idp_identify_words dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .word_out, .word_valid,
      .word_ready, .busy);
   idp_host_model u_host (.aclk, .aresetn, .word_out, .word_valid,
      .word_ready, .slow, .n_got);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // both channels offered together; each dropped once its handshake lands;
   // bready and rready stay up between calls so back to back calls never
   // drive one signal twice in a step
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic at, wt, bt;
      int   n;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bt = 1'b0;
      n = 0;
      while (!bt && n < 100) begin
         @(negedge aclk);
         at = s_axi_awvalid && s_axi_awready;
         wt = s_axi_wvalid && s_axi_wready;
         bt = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (at) s_axi_awvalid <= 1'b0;
         if (wt) s_axi_wvalid <= 1'b0;
         n++;
      end
      if (!bt) n_mismatch++;
   endtask

   task automatic rd(input logic [4:0] a);
      logic at, rt;
      int   n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rt = 1'b0;
      n = 0;
      while (!rt && n < 100) begin
         @(negedge aclk);
         at = s_axi_arvalid && s_axi_arready;
         rt = s_axi_rvalid;
         rdat = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (at) s_axi_arvalid <= 1'b0;
         n++;
      end
      if (!rt) n_mismatch++;
   endtask

   function automatic logic [15:0] exp_w(input int i);
      logic [31:0] cap;
      cap = 32'(cyl) * 32'(heads) * 32'(spt);
      case (i)
         49: return 16'h0B00;
         51: return 16'h0200;
         53: return 16'h0007;
         54: return cyl;
         55: return {8'h00, heads};
         56: return {8'h00, spt};
         57: return cap[15:0];
         58: return cap[31:16];
         59: return {8'h01, mult};
         60: return lba[15:0];
         61: return lba[31:16];
         63: return {5'h00, mdma, 8'h07};
         64: return 16'h0003;
         65, 66, 67, 68: return 16'h0078;
         80: return 16'h007E;
         81: return 16'h0019;
         82: return 16'h706B;
         83: return 16'h400C;
         84, 87: return 16'h4000;
         85: return {1'b0, feat[6:4], 5'h00, feat[3:2], 1'b0, feat[1],
                     1'b0, feat[0], 1'b0};
         86: return 16'h0100;
         88: return {3'h0, udma, 8'h1F};
         89: return {8'h00, erase};
         default: return 16'h0000;
      endcase
   endfunction

   // mid: rewrite geometry and restart while streaming; neither may show
   task automatic sector(input logic s, input logic mid);
      int base, n;
      slow <= s;
      base = n_got;
      wr(5'h00, 32'h1);
      if (mid) begin
         wr(5'h04, 32'h0);
         wr(5'h00, 32'h1);
      end
      n = 0;
      while (n_got < base + 256 && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      repeat (8) @(posedge aclk);
      chk(32'(n_got - base), 32'd256);
      for (int i = 0; i < 256; i++)
         chk(32'(u_host.mem[(base + i) % 256]), 32'(exp_w(i)));
      rd(5'h18);
      chk(rdat & 32'h1, 32'h0);
   endtask

   task automatic xfer(input logic [7:0] c);
      logic       err;
      logic [4:0] k;
      logic [2:0] m;
      k = c[7:3];
      m = c[2:0];
      err = !((k == 5'h00 && m <= 3'h1) || (k == 5'h01 && m <= 3'h4) ||
              (k == 5'h04 && m <= 3'h2) || (k == 5'h08 && m <= 3'h4));
      if (!err && k == 5'h04) {udma, mdma} = {5'h00, 3'h1 << m};
      if (!err && k == 5'h08) {udma, mdma} = {5'h01 << m, 3'h0};
      wr(5'h10, {24'h0, c});
      rd(5'h10);
      chk(rdat & 32'h1FF, {23'h0, err, c});
   endtask

   initial begin
      aresetn = 1'b0;
      slow = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      {cyl, heads, spt, lba, mult, feat, erase, mdma, udma} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int k = 1; k < 7; k++) begin
         rd(5'(4 * k));
         chk(rdat, 32'h0);
      end
      rd(5'h1C);
      chk(rdat, 32'h0);
      chk(32'(resp), 32'h2);
      wr(5'h1C, 32'hFFFF_FFFF);
      chk(32'(resp), 32'h2);
      sector(1'b0, 1'b0);
      {spt, heads, cyl} = 32'h3F10_1E5C;
      lba = 32'h0007_8ABC;
      mult = 8'h10;
      feat = 7'h7F;
      erase = 8'h2A;
      wr(5'h04, {spt, heads, cyl});
      wr(5'h08, lba);
      wr(5'h0C, {24'h0, mult});
      wr(5'h14, {16'h0, erase, 1'b0, feat});
      rd(5'h14);
      chk(rdat, {16'h0, erase, 1'b0, feat});
      for (int j = 0; j < 13; j++)
         xfer(CODES[103 - 8 * j -: 8]);
      sector(1'b1, 1'b0);
      xfer(8'h43);
      xfer(8'h27);
      sector(1'b0, 1'b1);
      // reset in the middle of a sector: stream stops, settings clear
      wr(5'h00, 32'h1);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(5'h18);
      chk(rdat, 32'h0);
      rd(5'h08);
      chk(rdat, 32'h0);
      rd(5'h14);
      chk(rdat, 32'h0);
      wrap_up();
   end

   initial begin
      #1_000_000;
      n_mismatch++;
      wrap_up();
   end
endmodule

bind idp_identify_words idp_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .word_out(word_out), .word_valid(word_valid), .word_ready(word_ready),
   .busy(busy));
`default_nettype wire
